/* hw/dotl_cfg.svh */
// configuration constants for the drive output terminal logic
`ifndef DOTL_CFG_SVH
`define DOTL_CFG_SVH
`define DOTL_CLK_HZ        100000000
`define DOTL_PULSE_MS      500
`define DOTL_PULSE_CYC     ((`DOTL_CLK_HZ / 1000) * `DOTL_PULSE_MS)
`define DOTL_TICK_MS       100
`define DOTL_TICK_CYC      ((`DOTL_CLK_HZ / 1000) * `DOTL_TICK_MS)
`define DOTL_UV_SETTLE_MS  100
`define DOTL_UV_SETTLE_CYC ((`DOTL_CLK_HZ / 1000) * `DOTL_UV_SETTLE_MS)
`define DOTL_OFF_FUNC      8'h00
`define DOTL_OFF_ARRW      8'h04
`define DOTL_OFF_LVL1      8'h08
`define DOTL_OFF_WID1      8'h0C
`define DOTL_OFF_LVL2      8'h10
`define DOTL_OFF_WID2      8'h14
`define DOTL_OFF_OVL       8'h18
`define DOTL_OFF_DLY       8'h1C
`define DOTL_OFF_CNT       8'h20
`define DOTL_OFF_AOUT      8'h24
`define DOTL_OFF_UVTH      8'h28
`define DOTL_OFF_STAT      8'h2C
`define DOTL_OFF_CNTVAL    8'h30
`define DOTL_RST_FUNC      32'h0000_0101
`define DOTL_RST_ARRW      32'h0000_00FA
`define DOTL_RST_LVL1      32'h0000_1388
`define DOTL_RST_WID1      32'h0000_0064
`define DOTL_RST_LVL2      32'h0000_09C4
`define DOTL_RST_WID2      32'h0000_0064
`define DOTL_RST_OVL       32'h03E8_044C
`define DOTL_RST_DLY       32'h0014_0014
`define DOTL_RST_CNT       32'h0000_0000
`define DOTL_RST_AOUT      32'h0064_0000
`define DOTL_RST_UVTH      32'h0000_01AE
`define DOTL_VMAX_MV       16'h2710
`define DOTL_VOFS_MV       16'h07D0
`endif

/* hw/dotl_pkg.sv */
// types shared by the drive output terminal logic
`default_nettype none
package dotl_pkg;
  typedef struct packed {
    logic        running;
    logic        runCmd;
    logic        faultAny;
    logic        extFault;
    logic        dcBrake;
    logic        reversing;
    logic        softStartErr;
    logic        stageEnd;
    logic        stageZero;
    logic        cycleEnd;
    logic [1:0]  seqRunMode;
    logic        countEdge;
    logic        clearEdge;
    logic        dinCfgChg;
  } dotl_status_t;
  typedef struct packed {
    logic [15:0] outFreq;
    logic [15:0] setFreq;
    logic [15:0] outCurPct;
    logic [15:0] motCurPct;
    logic [15:0] outVolt;
    logic [15:0] outPower;
    logic [15:0] busVolt;
    logic [15:0] vIn;
    logic [15:0] cIn;
  } dotl_meas_t;
  typedef enum logic [1:0] {
    DOTL_UV_OK     = 2'b00,
    DOTL_UV_LOW    = 2'b01,
    DOTL_UV_SETTLE = 2'b11
  } dotl_uv_t;
endpackage : dotl_pkg
`default_nettype wire

/* hw/dotl_top.sv */
// output terminal functions, counters, detectors and analog scaling
// Functional notes
// R1 - code 0: ready when no fault, no run
// R2 - code 1: active while running, zero included
// R3 - code 2: active during start/stop DC braking
// R4 - code 3: zero speed, not during reversal
// R5 - code 7: 0.5 s pulse per stage end
// R6 - zero-time stage gives no pulse
// R7 - stage end during pulse restarts timer
// R8 - code 8: 0.5 s pulse per cycle end
// R9 - code 10: undervoltage or soft-start error
// R10 - code 14 any fault, 13 external fault
// R11 - code 16: count equals target, until next pulse
// R12 - code 17: count equals middle, until next pulse
// R13 - counter holds at reached value until cleared
// R14 - after clear, next count edge drops flags
// R15 - setting change resets counter and flags
// R16 - source keeps count input under 50 Hz
// R17 - code 4: |fout - fset| within width
// R18 - codes 5,6: level detect with hysteresis
// R19 - code 11: drive overload after delay
// R20 - code 12: motor overload after delay
// R21 - analog source select 0 to 7; select 3 picks no source and gives 0
// R22 - 0-10 V or 2-10 V, gain, clip
// R23 - reserved codes 9, 15 hold inactive
`include "dotl_cfg.svh"
`default_nettype none
module dotl_top (
  input  wire logic                 clk_sys,          // 100 MHz control clock
  input  wire logic                 rst_n,            // synchronous reset, active low
  input  wire logic                 clkEn,            // freezes all state while low
  input  wire dotl_pkg::dotl_status_t stat,           // drive status and events
  input  wire dotl_pkg::dotl_meas_t meas,             // measured quantities
  input  wire logic [7:0]           avs_address,      // byte address
  input  wire logic                 avs_read,         // read request
  input  wire logic                 avs_write,        // write request
  input  wire logic [31:0]          avs_writedata,    // write data
  input  wire logic [3:0]           avs_byteenable,   // byte lanes
  output logic [31:0]               avs_readdata,     // read data
  output logic                      avs_waitrequest,  // stall
  output logic                      openCollectorOut, // open collector terminal
  output logic                      relayOut,         // relay terminal
  output logic [15:0]               analogOutMv       // analog channel level, mV
);
  localparam int PULSE_CYC = `DOTL_PULSE_CYC;
  localparam int TICK_CYC  = `DOTL_TICK_CYC;
  localparam int UV_CYC    = `DOTL_UV_SETTLE_CYC;
  default clocking sysCb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // register file
  logic [31:0] regs_r [0:10];
  logic [31:0] regs_nxt [0:10];
  logic        ack_r;
  logic [31:0] rdata_r;
  wire  [3:0]  regIdx   = avs_address[5:2];
  wire         regHit   = (avs_address[7:6] == 2'b00) && (regIdx <= 4'd10);
  wire         wrStrobe = avs_write && !ack_r && clkEn;
  wire  [31:0] beMask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] rstVal [0:10] = '{`DOTL_RST_FUNC, `DOTL_RST_ARRW, `DOTL_RST_LVL1,
    `DOTL_RST_WID1, `DOTL_RST_LVL2, `DOTL_RST_WID2, `DOTL_RST_OVL, `DOTL_RST_DLY,
    `DOTL_RST_CNT, `DOTL_RST_AOUT, `DOTL_RST_UVTH};
  genvar gi;
  generate
    for (gi = 0; gi < 11; gi++) begin : gReg
      wire hitThis = wrStrobe && regHit && (regIdx == 4'(gi));
      assign regs_nxt[gi] = hitThis ? ((regs_r[gi] & ~beMask) | (avs_writedata & beMask))
                                    : regs_r[gi];
      always_ff @(posedge clk_sys) begin
        if (!rst_n) regs_r[gi] <= rstVal[gi];
        else if (clkEn) regs_r[gi] <= regs_nxt[gi];
      end
    end
  endgenerate

  wire [4:0]  ocFunc   = regs_r[0][4:0];
  wire [4:0]  rlFunc   = regs_r[0][12:8];
  wire [15:0] arrWidth = regs_r[1][15:0];
  wire [15:0] lvl1     = regs_r[2][15:0];
  wire [15:0] wid1     = regs_r[3][15:0];
  wire [15:0] lvl2     = regs_r[4][15:0];
  wire [15:0] wid2     = regs_r[5][15:0];
  wire [15:0] drvOvlTh = regs_r[6][15:0];
  wire [15:0] motOvlTh = regs_r[6][31:16];
  wire [15:0] drvDly   = regs_r[7][15:0];
  wire [15:0] motDly   = regs_r[7][31:16];
  wire [13:0] midCount = regs_r[8][13:0];
  wire [13:0] tgtCount = regs_r[8][29:16];
  wire [2:0]  aoSel    = regs_r[9][2:0];
  wire        aoMode   = regs_r[9][8];
  wire [15:0] aoGain   = regs_r[9][31:16];
  wire [15:0] uvThresh = regs_r[10][15:0];
  wire        cntCfgWr = wrStrobe && regHit && (regIdx == 4'd8);

  // 100 ms tick for overload delays
  logic [23:0] tick_r;
  wire         tickHit = (tick_r == 24'(TICK_CYC - 1));
  always_ff @(posedge clk_sys) begin
    if (!rst_n) tick_r <= '0;
    else if (clkEn) tick_r <= tickHit ? '0 : tick_r + 24'h1;
  end

  // pulse timers: stage end (code 7) and cycle end (code 8)
  wire seqOn    = (stat.seqRunMode != 2'b00);
  wire stageEvt = seqOn && stat.stageEnd && !stat.stageZero;    // [R5] [R6]
  wire cycleEvt = seqOn && stat.cycleEnd;                       // [R8]
  logic [26:0] stagePulse_r;
  logic [26:0] cyclePulse_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stagePulse_r <= '0;
      cyclePulse_r <= '0;
    end else if (clkEn) begin
      if (stageEvt) stagePulse_r <= 27'(PULSE_CYC);             // [R7]
      else if (stagePulse_r != '0) stagePulse_r <= stagePulse_r - 27'h1;
      if (cycleEvt) cyclePulse_r <= 27'(PULSE_CYC);
      else if (cyclePulse_r != '0) cyclePulse_r <= cyclePulse_r - 27'h1;
    end
  end

  // undervoltage with settling time after recovery
  dotl_pkg::dotl_uv_t uvState_r;
  logic [23:0] uvCnt_r;
  wire busLow = (meas.busVolt < uvThresh);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      uvState_r <= dotl_pkg::DOTL_UV_OK;
      uvCnt_r   <= '0;
    end else if (clkEn) begin
      case (uvState_r)
        dotl_pkg::DOTL_UV_OK: if (busLow) uvState_r <= dotl_pkg::DOTL_UV_LOW;
        dotl_pkg::DOTL_UV_LOW: if (!busLow) begin
          uvState_r <= dotl_pkg::DOTL_UV_SETTLE;
          uvCnt_r   <= '0;
        end
        dotl_pkg::DOTL_UV_SETTLE: begin
          if (busLow) uvState_r <= dotl_pkg::DOTL_UV_LOW;
          else if (uvCnt_r == 24'(UV_CYC - 1)) uvState_r <= dotl_pkg::DOTL_UV_OK;
          else uvCnt_r <= uvCnt_r + 24'h1;
        end
        default: uvState_r <= dotl_pkg::DOTL_UV_OK;
      endcase
    end
  end
  wire underVolt = (uvState_r != dotl_pkg::DOTL_UV_OK) || stat.softStartErr; // [R9]

  // event counter; holds once a reached value is met
  logic [13:0] count_r;
  logic        tgtHit_r;
  logic        midHit_r;
  logic        cleared_r;
  wire atTarget = (count_r == tgtCount);
  wire holdCnt  = tgtHit_r || (count_r == tgtCount && count_r != 14'h0);
  wire [13:0] cntInc = count_r + 14'h1;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_r   <= '0;
      tgtHit_r  <= 1'b0;
      midHit_r  <= 1'b0;
      cleared_r <= 1'b0;
    end else if (clkEn) begin
      if (cntCfgWr || stat.dinCfgChg) begin                     // [R15]
        count_r   <= '0;
        tgtHit_r  <= 1'b0;
        midHit_r  <= 1'b0;
        cleared_r <= 1'b0;
      end else if (stat.clearEdge) begin                        // [R13]
        count_r   <= '0;
        cleared_r <= 1'b1;
      end else if (stat.countEdge) begin
        if (cleared_r) begin                                    // [R14]
          tgtHit_r  <= 1'b0;
          midHit_r  <= 1'b0;
          cleared_r <= 1'b0;
          count_r   <= 14'h1;
        end else if (!holdCnt) begin                            // [R13]
          count_r  <= cntInc;
          tgtHit_r <= (cntInc == tgtCount);                     // [R11]
          midHit_r <= (cntInc == midCount) ? 1'b1 : (midHit_r && atTarget); // [R12]
        end else begin
          tgtHit_r <= 1'b1;
        end
      end
    end
  end

  // frequency arrival and level detection
  wire [15:0] freqDiff = (meas.outFreq >= meas.setFreq) ? meas.outFreq - meas.setFreq
                                                        : meas.setFreq - meas.outFreq;
  wire freqArrive = (freqDiff <= arrWidth);                     // [R17]
  logic lvl1_r;
  logic lvl2_r;
  wire [15:0] rel1 = (lvl1 > wid1) ? lvl1 - wid1 : 16'h0;
  wire [15:0] rel2 = (lvl2 > wid2) ? lvl2 - wid2 : 16'h0;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lvl1_r <= 1'b0;
      lvl2_r <= 1'b0;
    end else if (clkEn) begin
      if (meas.outFreq > lvl1) lvl1_r <= 1'b1;                  // [R18]
      else if (meas.outFreq < rel1) lvl1_r <= 1'b0;
      if (meas.outFreq > lvl2) lvl2_r <= 1'b1;                  // [R18]
      else if (meas.outFreq < rel2) lvl2_r <= 1'b0;
    end
  end

  // overload pre-warnings, delay counted in 0.1 s ticks
  logic [15:0] drvTicks_r;
  logic [15:0] motTicks_r;
  wire drvOver = (meas.outCurPct > drvOvlTh);
  wire motOver = (meas.motCurPct > motOvlTh);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      drvTicks_r <= '0;
      motTicks_r <= '0;
    end else if (clkEn) begin
      if (!drvOver) drvTicks_r <= '0;                           // [R19]
      else if (tickHit && drvTicks_r < drvDly) drvTicks_r <= drvTicks_r + 16'h1;
      if (!motOver) motTicks_r <= '0;                           // [R20]
      else if (tickHit && motTicks_r < motDly) motTicks_r <= motTicks_r + 16'h1;
    end
  end
  // tick phase makes the delay up to 0.1 s short; fine for a pre-warning
  wire drvWarn = drvOver && (drvTicks_r >= drvDly);             // [R19]
  wire motWarn = motOver && (motTicks_r >= motDly);             // [R20]

  // terminal function map
  wire zeroSpeed = stat.running && (meas.outFreq == 16'h0) && !stat.reversing;
  wire [17:0] funcVec = {
    midHit_r,                        // 17
    tgtHit_r,                        // 16
    1'b0,                            // 15 reserved
    stat.faultAny,                   // 14
    stat.extFault,                   // 13
    motWarn,                         // 12
    drvWarn,                         // 11
    underVolt,                       // 10
    1'b0,                            // 9 reserved
    cyclePulse_r != '0,              // 8
    stagePulse_r != '0,              // 7
    lvl2_r,                          // 6
    lvl1_r,                          // 5
    freqArrive,                      // 4
    zeroSpeed,                       // 3 [R4]
    stat.dcBrake,                    // 2 [R3]
    stat.running,                    // 1 [R2]
    !stat.faultAny && !stat.runCmd   // 0 [R1]
  };
  // [R10] codes 13 and 14 follow the fault flags; [R23] reserved codes read 0
  wire ocNxt = (ocFunc <= 5'd17) ? funcVec[ocFunc] : 1'b0;
  wire rlNxt = (rlFunc <= 5'd17) ? funcVec[rlFunc] : 1'b0;

  // analog output: source select, offset, gain (x0.01), clip
  logic [15:0] aoSrc;
  always_comb begin
    case (aoSel)                                                // [R21]
      3'd0: aoSrc = meas.outFreq;
      3'd1: aoSrc = meas.setFreq;
      3'd2: aoSrc = meas.outCurPct;
      3'd4: aoSrc = meas.outVolt;
      3'd5: aoSrc = meas.outPower;
      3'd6: aoSrc = meas.vIn;
      3'd7: aoSrc = meas.cIn;
      default: aoSrc = 16'h0;
    endcase
  end
  // source is a per-mille fraction of full scale
  wire [31:0] spanMv = aoMode ? 32'(`DOTL_VMAX_MV - `DOTL_VOFS_MV) : 32'(`DOTL_VMAX_MV);
  wire [31:0] srcMv  = ((aoSrc > 16'h03E8) ? 32'h3E8 : 32'(aoSrc)) * spanMv / 32'h3E8;
  wire [31:0] baseMv = srcMv + (aoMode ? 32'(`DOTL_VOFS_MV) : 32'h0);
  wire [47:0] gainMv = 48'(baseMv) * 48'(aoGain) / 48'h64;
  wire [15:0] aoNxt  = (gainMv > 48'(`DOTL_VMAX_MV)) ? `DOTL_VMAX_MV : gainMv[15:0]; // [R22]

  // bus answer: one wait cycle, unmapped reads give zero
  wire busReq = (avs_read || avs_write) && !ack_r;
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    if (regHit) rdMux = regs_r[regIdx];
    else if (avs_address == `DOTL_OFF_STAT)
      rdMux = {14'h0, midHit_r, tgtHit_r, funcVec[15:0]};
    else if (avs_address == `DOTL_OFF_CNTVAL) rdMux = {18'h0, count_r};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_r            <= 1'b0;
      avs_waitrequest  <= 1'b1;
      rdata_r          <= '0;
      openCollectorOut <= 1'b0;
      relayOut         <= 1'b0;
      analogOutMv      <= '0;
    end else if (clkEn) begin
      ack_r            <= busReq;
      avs_waitrequest  <= !busReq;
      rdata_r          <= rdMux;
      openCollectorOut <= ocNxt;
      relayOut         <= rlNxt;
      analogOutMv      <= aoNxt;
    end
  end
  assign avs_readdata    = rdata_r;

  a_cycle_pulse_len: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R8]
    clkEn && cycleEvt |=> cyclePulse_r == 27'(PULSE_CYC))
    else $error("cycle pulse not loaded");
  a_stage_restart: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R7]
    clkEn && stageEvt |=> stagePulse_r == 27'(PULSE_CYC))
    else $error("stage pulse not restarted");
  a_zero_stage: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R6]
    clkEn && stat.stageZero && stagePulse_r == '0 |=> stagePulse_r == '0)
    else $error("zero stage made a pulse");
  a_reserved_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R23]
    clkEn && (ocFunc == 5'd9 || ocFunc == 5'd15) |=> !openCollectorOut)
    else $error("reserved code drove terminal");
  a_ready_out: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R1]
    clkEn && ocFunc == 5'd0 |=> openCollectorOut == !$past(stat.faultAny || stat.runCmd))
    else $error("ready output wrong");
  a_cfg_reset: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R15]
    clkEn && stat.dinCfgChg |=> count_r == '0 && !tgtHit_r && !midHit_r)
    else $error("counter not reset on change");
  a_cnt_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R13]
    clkEn && tgtHit_r && !stat.clearEdge && !stat.dinCfgChg && !cntCfgWr
      && !(cleared_r && stat.countEdge) |=> $stable(count_r))
    else $error("counter moved at target");
  a_drv_warn_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R19]
    clkEn && ocFunc == 5'd11 && !drvOver |=> !openCollectorOut)
    else $error("overload warn above no current");
  a_ao_clip: assert property (@(posedge clk_sys) disable iff (!rst_n) // [R22]
    analogOutMv <= `DOTL_VMAX_MV)
    else $error("analog output above 10 V");
  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && busReq |=> !avs_waitrequest)
    else $error("bus answer late");

  // terminal checks; outputs trail their inputs by one register
  a_run_out: assert property ( // [R2]
    clkEn && ocFunc == 5'd1 |=> openCollectorOut == $past(stat.running))
    else $error("run output wrong");
  a_brake_out: assert property ( // [R3]
    clkEn && rlFunc == 5'd2 |=> relayOut == $past(stat.dcBrake))
    else $error("brake output wrong");
  a_reverse_zero: assert property ( // [R4]
    clkEn && ocFunc == 5'd3 && stat.reversing |=> !openCollectorOut)
    else $error("zero speed during reversal");
  a_uv_soft: assert property ( // [R9]
    clkEn && ocFunc == 5'd10 && stat.softStartErr |=> openCollectorOut)
    else $error("soft-start error not shown");
  a_fault_out: assert property ( // [R10]
    clkEn && rlFunc == 5'd14 |=> relayOut == $past(stat.faultAny))
    else $error("fault output wrong");
  a_clear_keeps: assert property ( // [R14]
    clkEn && stat.clearEdge && !stat.dinCfgChg && !cntCfgWr |=> $stable({tgtHit_r, midHit_r}))
    else $error("clear dropped count flags");
  a_level_set: assert property ( // [R18]
    clkEn && meas.outFreq > lvl1 |=> lvl1_r)
    else $error("level detect not set");
  a_mot_warn_off: assert property ( // [R20]
    clkEn && rlFunc == 5'd12 && !motOver |=> !relayOut)
    else $error("motor warn without current");
  a_stage_idle: assert property ( // [R5]
    clkEn && !seqOn && stagePulse_r == '0 |=> stagePulse_r == '0)
    else $error("stage pulse with sequencer off");
  c_stage_pulse: cover property (@(posedge clk_sys) stageEvt);
  c_target_hit: cover property (@(posedge clk_sys) tgtHit_r && midHit_r);
  c_uv_settle: cover property (@(posedge clk_sys) uvState_r == dotl_pkg::DOTL_UV_SETTLE);
  c_ovl_warn: cover property (@(posedge clk_sys) drvWarn && motWarn);
endmodule : dotl_top
`default_nettype wire

/* verification/dotl_count_src.sv */
// counting input source model: count, clear and config-change pulses
`default_nettype none
module dotl_count_src #(
  parameter int GAP = 6  // idle cycles after a pulse, shortened from the 8 ms minimum
) (
  input  wire logic clk_sys,  // control clock
  output logic      cntEdge,  // valid counting edge
  output logic      clrEdge,  // valid clear edge
  output logic      cfgChg    // input terminal configuration changed
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cntEdge = 1'b0;
    clrEdge = 1'b0;
    cfgChg  = 1'b0;
  end
  // one pulse at a time; the gap keeps both phases of the input apart
  task automatic send(input int kind);
    @(posedge clk_sys);
    cntEdge <= (kind == 1);
    clrEdge <= (kind == 2);
    cfgChg  <= (kind == 3);
    @(posedge clk_sys);
    cntEdge <= 1'b0;
    clrEdge <= 1'b0;
    cfgChg  <= 1'b0;
    repeat (GAP) @(posedge clk_sys);
  endtask : send
endmodule : dotl_count_src
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the drive output terminal logic
`include "dotl_cfg.svh"
`default_nettype none
`define CHK(nm, ex, gt) begin \
  totalChecks++; \
  if ((gt) !== (ex)) begin \
    failCount++; \
    $display("mismatch %s exp %0h got %0h", nm, ex, gt); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk_sys;
  logic                   rst_n;
  logic                   clkEn;
  dotl_pkg::dotl_status_t statBase;
  dotl_pkg::dotl_status_t statIn;
  dotl_pkg::dotl_meas_t   meas;
  logic [7:0]             avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   openCollectorOut;
  logic                   relayOut;
  logic [15:0]            analogOutMv;
  logic                   cntEdge;
  logic                   clrEdge;
  logic                   cfgChg;
  logic [31:0]            rdq;
  int                     failCount;
  int                     totalChecks;
  int          codes[10] = '{0, 1, 2, 3, 4, 9, 10, 13, 14, 15};
  int          offs[11]  = '{0, 4, 8, 12, 16, 20, 24, 28, 32, 36, 40};
  logic [31:0] rsts[11]  = '{`DOTL_RST_FUNC, `DOTL_RST_ARRW, `DOTL_RST_LVL1,
                             `DOTL_RST_WID1, `DOTL_RST_LVL2, `DOTL_RST_WID2, `DOTL_RST_OVL,
                             `DOTL_RST_DLY, `DOTL_RST_CNT, `DOTL_RST_AOUT, `DOTL_RST_UVTH};
  int          fTab[7]   = '{4000, 5001, 4950, 4899, 2450, 2399, 2501};
  int          cSeq[16]  = '{1, 1, 1, 1, 1, 1, 2, 1, 1, 3, 1, 1, 1, 1, 0, 1};
  logic [31:0] aoTab[7]  = '{32'h0064_0006, 32'h0064_0007, 32'h0064_0106, 32'h01F4_0106,
                             32'h0000_0106, 32'h00C8_0006, 32'h0064_0103};
  int          aoSrc[7]  = '{250, 600, 500, 0, 700, 700, 900};

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  always_comb begin
    statIn           = statBase;
    statIn.countEdge = cntEdge;
    statIn.clearEdge = clrEdge;
    statIn.dinCfgChg = cfgChg;
  end

  dotl_top dotl_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .stat(statIn),
    .meas(meas), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .openCollectorOut(openCollectorOut),
    .relayOut(relayOut), .analogOutMv(analogOutMv));
  dotl_count_src #(.GAP(6)) dotl_count_src_i (.clk_sys(clk_sys), .cntEdge(cntEdge),
    .clrEdge(clrEdge), .cfgChg(cfgChg));

  task automatic complete_run();
    if (failCount == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // holds the request until waitrequest is sampled low; read data taken at that edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rdq = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 40) `CHK("busAck", 1'b0, avs_waitrequest)
  endtask : bus

  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask : settle

  task automatic setf(input int a, input int b);
    bus(1'b1, `DOTL_OFF_FUNC, {19'h0, 5'(b), 3'h0, 5'(a)});
  endtask : setf

  task automatic tchk(input int eo, input int er);
    `CHK("collectorOut", eo[0], openCollectorOut)
    `CHK("relayOut", er[0], relayOut)
  endtask : tchk

  task automatic pulse(input logic [2:0] k);
    @(posedge clk_sys);
    statBase.stageEnd  <= k[0];
    statBase.stageZero <= k[1];
    statBase.cycleEnd  <= k[2];
    @(posedge clk_sys);
    statBase.stageEnd  <= 1'b0;
    statBase.stageZero <= 1'b0;
    statBase.cycleEnd  <= 1'b0;
    settle();
  endtask : pulse

  // level functions of the terminal codes, from the bench's own copy of the inputs
  function automatic int tmodel(int c);
    int df;
    df = int'(meas.outFreq) - int'(meas.setFreq);
    if (df < 0) df = -df;
    case (c)
      0: return int'(!statBase.faultAny && !statBase.runCmd);
      1: return int'(statBase.running);
      2: return int'(statBase.dcBrake);
      3: return int'(statBase.running && meas.outFreq == 0 && !statBase.reversing);
      4: return int'(df <= 250);
      13: return int'(statBase.extFault);
      14: return int'(statBase.faultAny);
      default: return 0;
    endcase
  endfunction : tmodel

  initial begin
    repeat (60000) @(posedge clk_sys);
    failCount++;
    complete_run();
  end

  initial begin
    int ca, cb, f, dlt, cnt, mF, tF, h1, h2, x, v;
    logic [31:0] r;
    failCount = 0;
    totalChecks = 0;
    rst_n = 1'b0;
    clkEn = 1'b1;
    statBase = '0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    meas = '0;
    meas.busVolt = 16'h0258;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    void'($urandom(32'h2719));
    for (int i = 0; i < 11; i++) begin
      bus(1'b0, 8'(offs[i]), 32'h0);
      `CHK("regReset", rsts[i], rdq)
    end
    bus(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rdq)
    bus(1'b1, `DOTL_OFF_CNTVAL, 32'h0000_0055);
    bus(1'b0, `DOTL_OFF_CNTVAL, 32'h0);
    `CHK("readOnly", 32'h0, rdq)
    // soft-start error stays low here: the bench model gives 0 for code 10
    for (int i = 0; i < 40; i++) begin
      ca = codes[$urandom_range(9, 0)];
      cb = codes[$urandom_range(9, 0)];
      setf(ca, cb);
      r = $urandom;
      f = r[7] ? 0 : int'(r[20:12]);
      dlt = $urandom_range(500, 0);
      if (dlt == 250) dlt = 251;
      statBase.running   <= r[0];
      statBase.runCmd    <= r[1];
      statBase.faultAny  <= r[2] | r[3];
      statBase.extFault  <= r[3];
      statBase.dcBrake   <= r[4];
      statBase.reversing <= r[5];
      meas.outFreq <= 16'(r[8] ? f : f + dlt);
      meas.setFreq <= 16'(r[8] ? f + dlt : f);
      settle();
      tchk(tmodel(ca), tmodel(cb));
      bus(1'b0, `DOTL_OFF_STAT, 32'h0);
      `CHK("statusVec", 1'(tmodel(ca)), rdq[ca])
    end
    statBase <= '0;
    setf(5, 6);
    h1 = 0;
    h2 = 0;
    for (int i = 0; i < 7; i++) begin
      meas.outFreq <= 16'(fTab[i]);
      if (fTab[i] > 5000) h1 = 1;
      else if (fTab[i] < 4900) h1 = 0;
      if (fTab[i] > 2500) h2 = 1;
      else if (fTab[i] < 2400) h2 = 0;
      settle();
      tchk(h1, h2);
    end
    setf(16, 17);
    bus(1'b1, `DOTL_OFF_CNT, 32'h0004_0002);
    cnt = 0;
    mF = 0;
    tF = 0;
    foreach (cSeq[i]) begin
      if (cSeq[i] == 0) begin
        bus(1'b1, `DOTL_OFF_CNT, 32'h0004_0002);
        settle();
      end else begin
        dotl_count_src_i.send(cSeq[i]);
      end
      if (cSeq[i] == 1) begin
        if (cnt != 4) cnt++;
        tF = int'(cnt == 4);
        mF = int'(cnt == 2);
      end else begin
        cnt = 0;
        if (cSeq[i] != 2) tF = 0;
        if (cSeq[i] != 2) mF = 0;
      end
      tchk(tF, mF);
      bus(1'b0, `DOTL_OFF_CNTVAL, 32'h0);
      `CHK("countValue", cnt, rdq)
    end
    setf(7, 8);
    pulse(3'h1);
    tchk(0, 0);
    statBase.seqRunMode <= 2'h2;
    pulse(3'h3);
    tchk(0, 0);
    pulse(3'h1);
    tchk(1, 0);
    pulse(3'h4);
    tchk(1, 1);
    setf(11, 12);
    meas.outCurPct <= 16'h04B0;
    meas.motCurPct <= 16'h041A;
    repeat (20) @(posedge clk_sys);
    tchk(0, 0);
    bus(1'b1, `DOTL_OFF_DLY, 32'h0);
    settle();
    tchk(1, 1);
    meas.outCurPct <= 16'h03E8;
    meas.motCurPct <= 16'h0384;
    settle();
    tchk(0, 0);
    meas <= '{16'h006E, 16'h00DC, 16'h014A, 16'h0000, 16'h01B8, 16'h0226, 16'h0258,
              16'h0294, 16'h0302};
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `DOTL_OFF_AOUT, {16'h0064, 13'h0, 3'(i)});
      settle();
      v = (i == 3) ? 0 : 1100 * ((i < 3) ? i + 1 : i);
      `CHK("analogSel", v[15:0], analogOutMv)
    end
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, `DOTL_OFF_AOUT, aoTab[i]);
      meas.vIn <= 16'(aoSrc[i]);
      meas.cIn <= 16'(aoSrc[i]);
      settle();
      x = (aoTab[i][2:0] == 3'h3) ? 0 : aoSrc[i];
      v = aoTab[i][8] ? 2000 + 8 * x : 10 * x;
      v = v * int'(aoTab[i][31:16]) / 100;
      if (v > 10000) v = 10000;
      `CHK("analogOut", v[15:0], analogOutMv)
    end
    // last: after the bus recovers, the undervoltage indication is still held a few cycles into the settle time
    setf(10, 14);
    clkEn <= 1'b0;
    statBase.softStartErr <= 1'b1;
    settle();
    tchk(0, 0);
    clkEn <= 1'b1;
    settle();
    tchk(1, 0);
    meas.busVolt <= 16'h012C;
    statBase.softStartErr <= 1'b0;
    settle();
    tchk(1, 0);
    meas.busVolt <= 16'h0258;
    settle();
    tchk(1, 0);
    complete_run();
  end
endmodule : tb
`default_nettype wire
